/* File: rfi_pkg.sv */
// Constants, register layout and state types for the flag and interrupt block
package rfi_pkg;

    // Register map, printed offsets on the 4-bit register port
    localparam logic [3:0] ADDR_INT_CTRL = 4'hf;
    localparam logic [3:0] ADDR_STATUS_FLAGS = 4'he;

    // Interrupt control field positions
    localparam int CTRL_SEL_HI_BIT = 7;
    localparam int CTRL_SEL_LO_BIT = 6;
    localparam int CTRL_UIE_BIT = 5;
    localparam int CTRL_TIE_BIT = 4;
    localparam int CTRL_AIE_BIT = 3;
    localparam int CTRL_EIE_BIT = 2;
    localparam int CTRL_WP_BIT = 1;
    localparam int CTRL_CNT_RST_BIT = 0;

    // Status flag field positions
    localparam int FLAG_UPDATE_BIT = 5;
    localparam int FLAG_TIMER_BIT = 4;
    localparam int FLAG_ALARM_BIT = 3;
    localparam int FLAG_EXT_EVENT_BIT = 2;
    localparam int FLAG_DATA_LOSS_BIT = 1;
    localparam int FLAG_COMP_STOP_BIT = 0;

    // Power-up values
    localparam logic [1:0] RST_COMP_INTERVAL_SEL = 2'h1;
    localparam logic RST_DATA_LOSS_FLAG = 1'b1;
    localparam logic RST_COMP_STOP_FLAG = 1'b1;
    localparam logic RST_EXT_EVENT_IRQ_ENABLE = 1'b0;
    localparam logic RST_OTHER_BITS = 1'b0;

    // Compensation interval codes
    localparam logic [1:0] COMP_INTERVAL_0P5S = 2'h0;
    localparam logic [1:0] COMP_INTERVAL_2S = 2'h1;
    localparam logic [1:0] COMP_INTERVAL_10S = 2'h2;
    localparam logic [1:0] COMP_INTERVAL_30S = 2'h3;

    // Auto-release timing
    localparam longint CLK_PERIOD_NS = 50;
    localparam longint AUTO_RELEASE_NS = 7800000;
    localparam int RELEASE_CNT_W = 18;
    localparam logic [RELEASE_CNT_W-1:0] AUTO_RELEASE_CYCLES =
        RELEASE_CNT_W'(AUTO_RELEASE_NS / CLK_PERIOD_NS);

    // Hardware event pulses, one cycle each
    typedef struct packed {
        logic update;
        logic timer;
        logic alarm;
        logic ext_event;
        logic data_loss;
        logic comp_stop;
    } rfi_events_t;

    // Status flags, same order as the register
    typedef struct packed {
        logic update_flag;
        logic timer_flag;
        logic alarm_flag;
        logic ext_event_flag;
        logic data_loss_flag;
        logic comp_stop_flag;
    } rfi_flags_t;

    // Interrupt control bits
    typedef struct packed {
        logic comp_interval_sel_hi;
        logic comp_interval_sel_lo;
        logic update_irq_enable;
        logic timer_irq_enable;
        logic alarm_irq_enable;
        logic ext_event_irq_enable;
        logic counter_reset;
    } rfi_ctrl_t;

    // Whole block state
    typedef struct packed {
        rfi_flags_t flags;
        rfi_ctrl_t ctrl;
        logic [RELEASE_CNT_W-1:0] update_cnt;
        logic [RELEASE_CNT_W-1:0] timer_cnt;
        logic ext_req;
        logic int_oe_n;
        logic int_out;
        logic [7:0] rdata;
    } rfi_state_t;

endpackage : rfi_pkg

/* File: rfi_flag_irq.sv */
// Status flags, interrupt enables and shared open-drain interrupt output
// Functional notes
// - Event flag sets on event, held till 0-write
// - Data-loss flag sets on loss, held till 0-write
// - Data-loss flag reads 1 after power-up
// - Data-loss flag: write 0 clears, 1 ignored
// - Compensation-stop flag sets, held, 1 at power-up
// - Compensation-stop flag: write 0 clears, 1 ignored
// - Control bit 1 write-protected, reads zero
// - Interval select: 0.5, 2, 10, 30 s
// - Power-up: interval 01, event enable 0, bit1 0
// - Update rise drives pin low if enabled
// - Update request self-releases after 7.8 ms
// - Timer rise drives pin low if enabled
// - Timer request self-releases within 7.8 ms
// - Alarm rise drives pin low if enabled
// - Alarm request holds until alarm flag cleared
// - Clearing an enable cancels its request at once
// - Pin is OR of all enabled requests
// - Update, timer, alarm flags set, held till 0-write
// - Event flag rise drives pin low if enabled
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module rfi_flag_irq
    import rfi_pkg::*;
#(
    parameter logic [RELEASE_CNT_W-1:0] RELEASE_CYCLES = AUTO_RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // Register port
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // Hardware event pulses
    input wire rfi_events_t I_EVENTS,
    // Control outputs to the clock core
    output logic [1:0] O_COMP_INTERVAL_SEL,
    output logic O_COUNTER_RESET,
    // Open-drain interrupt pin
    output logic O_INT_OUT,
    output logic O_INT_OE_N
);

    rfi_state_t cur;
    rfi_state_t next_cur;

    // Decoded accesses and flag bookkeeping
    logic wr_ctrl;
    logic wr_flags;
    logic rd_ctrl;
    logic rd_flags;
    rfi_flags_t flag_clr;
    rfi_flags_t flag_set;
    rfi_flags_t flag_rise;
    logic alarm_req;
    logic any_req;

    // Register decode
    always_comb begin
        wr_ctrl = I_WR && (I_ADDR == ADDR_INT_CTRL);
        wr_flags = I_WR && (I_ADDR == ADDR_STATUS_FLAGS);
        rd_ctrl = I_RD && (I_ADDR == ADDR_INT_CTRL);
        rd_flags = I_RD && (I_ADDR == ADDR_STATUS_FLAGS);
    end

    // Event pulses mapped onto the flags they set
    always_comb begin
        flag_set.update_flag = I_EVENTS.update;
        flag_set.timer_flag = I_EVENTS.timer;
        flag_set.alarm_flag = I_EVENTS.alarm;
        flag_set.ext_event_flag = I_EVENTS.ext_event;
        flag_set.data_loss_flag = I_EVENTS.data_loss;
        flag_set.comp_stop_flag = I_EVENTS.comp_stop;
    end

    // Zero written to a flag bit clears it; a one is ignored
    always_comb begin
        flag_clr.update_flag = wr_flags && !I_WDATA[FLAG_UPDATE_BIT];
        flag_clr.timer_flag = wr_flags && !I_WDATA[FLAG_TIMER_BIT];
        flag_clr.alarm_flag = wr_flags && !I_WDATA[FLAG_ALARM_BIT];
        flag_clr.ext_event_flag = wr_flags && !I_WDATA[FLAG_EXT_EVENT_BIT];
        flag_clr.data_loss_flag = wr_flags && !I_WDATA[FLAG_DATA_LOSS_BIT];
        flag_clr.comp_stop_flag = wr_flags && !I_WDATA[FLAG_COMP_STOP_BIT];
    end

    // A fresh event counts as a rise even when it lands on a clear
    always_comb begin
        flag_rise = flag_set & (~cur.flags | flag_clr);
    end

    // Next state
    always_comb begin
        next_cur = cur;

        // Set wins over clear so no event is lost
        next_cur.flags = (cur.flags & ~flag_clr) | flag_set;

        // Control write; bit 1 has no storage at all
        if (wr_ctrl) begin
            next_cur.ctrl.comp_interval_sel_hi = I_WDATA[CTRL_SEL_HI_BIT];
            next_cur.ctrl.comp_interval_sel_lo = I_WDATA[CTRL_SEL_LO_BIT];
            next_cur.ctrl.update_irq_enable = I_WDATA[CTRL_UIE_BIT];
            next_cur.ctrl.timer_irq_enable = I_WDATA[CTRL_TIE_BIT];
            next_cur.ctrl.alarm_irq_enable = I_WDATA[CTRL_AIE_BIT];
            next_cur.ctrl.ext_event_irq_enable = I_WDATA[CTRL_EIE_BIT];
            next_cur.ctrl.counter_reset = I_WDATA[CTRL_CNT_RST_BIT];
        end

        // Update request: loaded on an enabled rise, runs down to release
        if (!next_cur.ctrl.update_irq_enable || !next_cur.flags.update_flag) begin
            next_cur.update_cnt = '0;
        end else if (flag_rise.update_flag) begin
            next_cur.update_cnt = RELEASE_CYCLES;
        end else if (cur.update_cnt != '0) begin
            next_cur.update_cnt = cur.update_cnt - RELEASE_CNT_W'(1);
        end

        // Timer request: same shape, release bound is the same window
        if (!next_cur.ctrl.timer_irq_enable || !next_cur.flags.timer_flag) begin
            next_cur.timer_cnt = '0;
        end else if (flag_rise.timer_flag) begin
            next_cur.timer_cnt = RELEASE_CYCLES;
        end else if (cur.timer_cnt != '0) begin
            next_cur.timer_cnt = cur.timer_cnt - RELEASE_CNT_W'(1);
        end

        // External event request holds with its flag, no timeout
        if (!next_cur.ctrl.ext_event_irq_enable || !next_cur.flags.ext_event_flag) begin
            next_cur.ext_req = 1'b0;
        end else if (flag_rise.ext_event_flag) begin
            next_cur.ext_req = 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        if (rd_ctrl) begin
            next_cur.rdata = {cur.ctrl.comp_interval_sel_hi, cur.ctrl.comp_interval_sel_lo,
                cur.ctrl.update_irq_enable, cur.ctrl.timer_irq_enable,
                cur.ctrl.alarm_irq_enable, cur.ctrl.ext_event_irq_enable,
                1'b0, cur.ctrl.counter_reset};
        end else if (rd_flags) begin
            next_cur.rdata = {2'h0, cur.flags};
        end else begin
            next_cur.rdata = 8'h00;
        end

        // Alarm request follows flag and enable with no timeout
        alarm_req = next_cur.flags.alarm_flag && next_cur.ctrl.alarm_irq_enable;

        // Requests merged here, not in a separate process, so no loop through next_cur
        any_req = (next_cur.update_cnt != '0) || (next_cur.timer_cnt != '0)
            || alarm_req || next_cur.ext_req;

        // Pin level only ever low; the enable decides if it is driven
        next_cur.int_out = 1'b0;
        next_cur.int_oe_n = !any_req;
    end

    // State register; power-up values loaded by reset
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cur.flags.update_flag <= RST_OTHER_BITS;
            cur.flags.timer_flag <= RST_OTHER_BITS;
            cur.flags.alarm_flag <= RST_OTHER_BITS;
            cur.flags.ext_event_flag <= RST_OTHER_BITS;
            cur.flags.data_loss_flag <= RST_DATA_LOSS_FLAG;
            cur.flags.comp_stop_flag <= RST_COMP_STOP_FLAG;
            cur.ctrl.comp_interval_sel_hi <= RST_COMP_INTERVAL_SEL[1];
            cur.ctrl.comp_interval_sel_lo <= RST_COMP_INTERVAL_SEL[0];
            cur.ctrl.update_irq_enable <= RST_OTHER_BITS;
            cur.ctrl.timer_irq_enable <= RST_OTHER_BITS;
            cur.ctrl.alarm_irq_enable <= RST_OTHER_BITS;
            cur.ctrl.ext_event_irq_enable <= RST_EXT_EVENT_IRQ_ENABLE;
            cur.ctrl.counter_reset <= RST_OTHER_BITS;
            cur.update_cnt <= '0;
            cur.timer_cnt <= '0;
            cur.ext_req <= 1'b0;
            cur.int_oe_n <= 1'b1;
            cur.int_out <= 1'b0;
            cur.rdata <= 8'h00;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign O_RDATA = cur.rdata;
    assign O_COMP_INTERVAL_SEL = {cur.ctrl.comp_interval_sel_hi,
        cur.ctrl.comp_interval_sel_lo};
    assign O_COUNTER_RESET = cur.ctrl.counter_reset;
    assign O_INT_OUT = cur.int_out;
    assign O_INT_OE_N = cur.int_oe_n;

endmodule : rfi_flag_irq

`default_nettype wire

/* File: rfi_flag_irq_asserts.sv */
// Port-level checks for the flag and interrupt block
`timescale 1ns/10ps
`default_nettype none
module rfi_flag_irq_asserts
    import rfi_pkg::*;
(
    // Clock, reset and register port
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    // Events and outputs
    input wire rfi_events_t I_EVENTS,
    input wire logic [1:0] O_COMP_INTERVAL_SEL,
    input wire logic O_INT_OUT,
    input wire logic O_INT_OE_N
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);
    // Decoded writes
    wire logic ctrl_wr = I_WR && I_ADDR == ADDR_INT_CTRL;
    wire logic flag_wr = I_WR && I_ADDR == ADDR_STATUS_FLAGS;
    property p_od; O_INT_OUT == 1'b0; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_bit1; $past(I_RD) && $past(I_ADDR) == ADDR_INT_CTRL |-> !O_RDATA[1]; endproperty
    a_bit1: assert property (p_bit1) else $error("ctrl bit1 set");
    property p_sel; ctrl_wr |=> {O_COMP_INTERVAL_SEL, 6'h00} == ($past(I_WDATA) & 8'hc0);
    endproperty
    a_sel: assert property (p_sel) else $error("interval select");
    property p_cause; $fell(O_INT_OE_N) |-> $past(I_WR) || ($past(I_EVENTS) & 6'h3c) != 6'h00;
    endproperty
    a_cause: assert property (p_cause) else $error("pin low without cause");
    property p_en_off; ctrl_wr && I_WDATA[5:2] == 4'h0 |=> O_INT_OE_N; endproperty
    a_en_off: assert property (p_en_off) else $error("pin kept after disable");
    property p_clr; flag_wr && I_WDATA[5:2] == 4'h0 && (I_EVENTS & 6'h3c) == 6'h00 |=> O_INT_OE_N;
    endproperty
    a_clr: assert property (p_clr) else $error("pin kept after clear");
    property p_loss; I_RD && I_ADDR == ADDR_STATUS_FLAGS && $past(I_EVENTS.data_loss) |=> O_RDATA[1];
    endproperty
    a_loss: assert property (p_loss) else $error("loss flag not set");
    property p_stop; I_RD && I_ADDR == ADDR_STATUS_FLAGS && $past(I_EVENTS.comp_stop) |=> O_RDATA[0];
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag not set");
endmodule : rfi_flag_irq_asserts
`default_nettype wire

/* File: rfi_host.sv */
// Host model: register accesses and the pulled-up interrupt line
`timescale 1ns/10ps
`default_nettype none
module rfi_host
    import rfi_pkg::*;
(
    // Clock and interrupt pin
    input wire logic i_clk,
    input wire logic i_int_out,
    input wire logic i_int_oe_n,
    output logic o_int_n,
    // Register port
    input wire logic [7:0] i_rdata,
    output var logic [3:0] o_addr,
    output var logic [7:0] o_wdata,
    output var logic o_wr,
    output var logic o_rd
);
    // Pull-up takes the line whenever the block lets go
    assign o_int_n = i_int_oe_n ? 1'b1 : i_int_out;
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Called just after an edge; idle edge after so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        d = i_rdata;
    endtask : rd
    // Lost data means nothing held can be trusted
    task automatic recover(output logic [7:0] f);
        rd(ADDR_STATUS_FLAGS, f);
        if (f[FLAG_DATA_LOSS_BIT]) begin
            wr(ADDR_INT_CTRL, 8'h40);
            wr(ADDR_STATUS_FLAGS, 8'h00);
        end
    endtask : recover
endmodule : rfi_host
`default_nettype wire

/* File: rfi_flag_irq_tb.sv */
// Self-checking bench for the flag and interrupt block
`timescale 1ns/10ps
`default_nettype none
module rfi_flag_irq_tb;
    import rfi_pkg::*;
    // Short auto-release keeps the run brief
    localparam logic [RELEASE_CNT_W-1:0] RC = 18'h14;
    localparam int WIN = 30;
    logic clk, rstn, wr, rd, cnt_rst, int_out, oe_n, int_n;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [1:0] sel;
    rfi_events_t ev;
    int num_errors, total_checks;
    rfi_flag_irq #(.RELEASE_CYCLES(RC)) u_rfi_flag_irq (.I_CORE_CLK(clk), .I_RSTN(rstn),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EVENTS(ev),
        .O_COMP_INTERVAL_SEL(sel), .O_COUNTER_RESET(cnt_rst), .O_INT_OUT(int_out),
        .O_INT_OE_N(oe_n));
    rfi_host u_rfi_host (.i_clk(clk), .i_int_out(int_out), .i_int_oe_n(oe_n),
        .o_int_n(int_n), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    always #25 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string nm);
        u_rfi_host.rd(a, d);
        chk(nm, e, d);
    endtask : rdchk
    // One-cycle event, then count low cycles of the pin in a fixed window
    task automatic pulse(input rfi_events_t m, output int n);
        ev <= m;
        @(posedge clk);
        ev <= '0;
        n = 0;
        repeat (WIN) begin
            @(posedge clk);
            if (int_n === 1'b0) n++;
        end
    endtask : pulse
    task automatic t_reset;
        rdchk(ADDR_INT_CTRL, 8'h40, "ctrl");
        chk("sel", 8'h01, {6'h00, sel});
        chk("counter reset", 8'h00, {7'h00, cnt_rst});
        u_rfi_host.wr(ADDR_STATUS_FLAGS, 8'hff);
        u_rfi_host.wr(4'h0, 8'hff);
        rdchk(4'h0, 8'h00, "unmapped");
        u_rfi_host.recover(d);
        chk("flags", 8'h03, d);
        rdchk(ADDR_STATUS_FLAGS, 8'h00, "flags");
    endtask : t_reset
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            u_rfi_host.wr(ADDR_INT_CTRL, {2'(c), 6'h03});
            rdchk(ADDR_INT_CTRL, {2'(c), 6'h01}, "ctrl");
            chk("sel", 8'(c), {6'h00, sel});
            chk("counter reset", 8'h01, {7'h00, cnt_rst});
        end
    endtask : t_codes
    // Enabled drive and hold, clear, disable, then a refused rise
    task automatic t_src(input logic [5:0] m, input logic [7:0] hold);
        int n;
        u_rfi_host.wr(ADDR_INT_CTRL, {2'h1, m});
        pulse(m, n);
        chk("low cycles", hold, 8'(n));
        rdchk(ADDR_STATUS_FLAGS, {2'h0, m}, "flags");
        u_rfi_host.wr(ADDR_STATUS_FLAGS, 8'h00);
        chk("pin after clear", 8'h01, {7'h00, int_n});
        // Drop the enable while the request is still live
        ev <= m;
        @(posedge clk);
        ev <= '0;
        @(posedge clk);
        chk("pin before disable", 8'h00, {7'h00, int_n});
        u_rfi_host.wr(ADDR_INT_CTRL, 8'h40);
        chk("pin after disable", 8'h01, {7'h00, int_n});
        u_rfi_host.wr(ADDR_STATUS_FLAGS, 8'h00);
        pulse(m, n);
        chk("refused low cycles", 8'h00, 8'(n));
        u_rfi_host.wr(ADDR_STATUS_FLAGS, 8'h00);
    endtask : t_src
    task automatic t_loss;
        ev <= 6'h03;
        @(posedge clk);
        ev <= '0;
        rdchk(ADDR_STATUS_FLAGS, 8'h03, "flags");
        chk("pin", 8'h01, {7'h00, int_n});
    endtask : t_loss
    task automatic close_out;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        ev = '0;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_codes;
        t_src(6'h20, 8'(RC));
        t_src(6'h10, 8'(RC));
        t_src(6'h08, 8'(WIN));
        t_src(6'h04, 8'(WIN));
        t_loss;
        close_out;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #500000;
        num_errors++;
        close_out;
    end
endmodule : rfi_flag_irq_tb
bind rfi_flag_irq rfi_flag_irq_asserts u_chk (.I_CORE_CLK, .I_RSTN, .I_ADDR, .I_WDATA,
    .I_WR, .I_RD, .O_RDATA, .I_EVENTS, .O_COMP_INTERVAL_SEL, .O_INT_OUT, .O_INT_OE_N);
`default_nettype wire
